/* File: pac_converter.sv */
// module: paging address code converter, decimal to words and back
//
// Function
// [R1] A-D single, E-H any, I-L all; subtract 0-3
// [R2] subtract letter value before frame/phase derivation
// [R3] U-X fix phase 0-3; Y any, Z all
// [R4] short: add 32768, emit one 21-bit word
// [R5] set 1-2 word1: (code-2068481) mod 32768 plus 1
// [R6] set 1-2 word2: ones complement of quotient
// [R7] sets 1-3/1-4 word2: quotient plus 1933312
// [R8] set 2-3 word1: (code-2068479) mod 32768 plus 2064383
// [R9] set 2-3 word2: quotient plus 1867776
// [R10] short word back: subtract 32768
// [R11] pair back: ~w2 times 32768 plus 2068480 plus w1
// [R12] zero illegal, short range, gap illegal
// [R13] long sets split at documented range ends
// [R14] assigner prefixes A/E/I then B/F/J
// [R15] error flag, no words on illegal input
module pac_converter
  import pac_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // request
  input  wire logic                req_valid,
  input  pac_pkg::pac_req_t        req,
  // result
  output logic                     rsp_valid,
  output pac_pkg::pac_rsp_t        rsp
);
  import pac_pkg::*;

  pac_type_t   typ;      // decoded letter
  pac_class_t  cls;      // class of the decimal input
  logic [32:0] emb;      // address after subtract
  logic [32:0] d12;      // code less set 1-2 base
  logic [32:0] d23;      // code less set 2-3 base
  logic [20:0] q12;      // quotient for sets 1-x
  logic [20:0] q23;      // quotient for set 2-3
  logic [32:0] back_l12; // rebuilt decimal of a 1-2 pair
  logic [32:0] sh_w;     // short address plus offset
  logic [32:0] back_sh;  // rebuilt decimal of a short word
  pac_rsp_t    res;      // next result
  logic        rsp_valid_r;
  pac_rsp_t    rsp_r;

  // letter decoder
  pac_letter_dec u_dec (
    .letter (req.letter),
    .typ    (typ)
  );

  // range classification of the decimal value
  always_comb begin
    if (req.dec == 33'h000000000)
      cls = PAC_CL_ILLEGAL; // [R12]
    else if (req.dec <= SHORT_MAX)
      cls = PAC_CL_SHORT; // [R12]
    else if (req.dec < SHORT_LIM)
      cls = PAC_CL_UNDEF; // special single-word ranges not converted
    else if (req.dec <= ILL_HI)
      cls = PAC_CL_ILLEGAL; // [R12]
    else if (req.dec <= L12_END)
      cls = PAC_CL_L12; // [R13]
    else if (req.dec <= L13_END)
      cls = PAC_CL_L13; // [R13]
    else if (req.dec <= L14_END)
      cls = PAC_CL_L14; // [R13]
    else if (req.dec <= L23_END)
      cls = PAC_CL_L23; // [R13]
    else
      cls = PAC_CL_UNDEF; // [R12]
  end

  // arithmetic for all conversions
  always_comb begin
    emb      = req.dec - {31'h0, typ.sub}; // [R2]
    d12      = req.dec - L12_BASE;
    d23      = req.dec - L23_BASE;
    // quotient by 32768 needs 18 bits at the top of the long range
    q12      = {3'h0, d12[32:15]};
    q23      = {3'h0, d23[32:15]};
    sh_w     = req.dec + SHORT_OFS; // [R4]
    back_sh  = {12'h000, req.w1} - SHORT_OFS; // [R10]
    // only the low 18 bits of the complement fit the 33-bit result
    back_l12 = {(~req.w2[17:0]), 15'h0000} + L12_REBASE
               + {12'h000, req.w1}; // [R11]
  end

  // form the next result
  always_comb begin
    res          = '0;
    res.cls      = cls;
    res.ptype    = typ.ptype;
    res.dec      = req.dec;
    res.err      = 1'b0;
    unique case (req.op)
      PAC_OP_SHORT_BK: begin
        // single received word back to decimal
        res.dec = back_sh; // [R10]
        res.cls = PAC_CL_SHORT;
        if (req.w1 <= SHORT_OFS[20:0] || req.w1 > 21'h1e0000)
          res.err = 1'b1; // [R15]
      end
      PAC_OP_L12_BK: begin
        // received set 1-2 pair back to decimal
        res.dec = back_l12; // [R11]
        res.cls = PAC_CL_L12;
        if (req.w1 == 21'h000000 || req.w1 > SHORT_OFS[20:0])
          res.err = 1'b1; // [R15]
      end
      default: begin
        // decimal to over-the-air words
        if (typ.fixed_ph)
          res.phase = typ.sub; // [R3]
        else if (typ.standard) begin
          res.phase = emb[3:2]; // [R2]
          res.frame = emb[10:4];
        end
        unique case (cls)
          PAC_CL_SHORT: begin
            res.w1 = sh_w[20:0]; // [R4]
          end
          PAC_CL_L12: begin
            res.w1 = 21'(d12[14:0]) + 21'h000001; // [R5]
            res.w2 = ONES_21 - q12; // [R6]
            res.two_words = 1'b1;
          end
          PAC_CL_L13, PAC_CL_L14: begin
            res.w1 = 21'(d12[14:0]) + 21'h000001; // [R7]
            res.w2 = q12 + L3_OFS; // [R7]
            res.two_words = 1'b1;
          end
          PAC_CL_L23: begin
            res.w1 = 21'(d23[14:0]) + L23_W1_OFS; // [R8]
            res.w2 = q23 + L23_W2_OFS; // [R9]
            res.two_words = 1'b1;
          end
          default: res.err = 1'b1; // [R15]
        endcase
        if (typ.bad)
          res.err = 1'b1; // [R15]
        if (res.err) begin
          // no valid words leave on error
          res.w1        = 21'h000000; // [R15]
          res.w2        = 21'h000000;
          res.two_words = 1'b0;
        end
      end
    endcase
  end

  // registered result, one cycle after the request
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= req_valid;
      if (req_valid)
        rsp_r <= res;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp       = rsp_r;

endmodule

/* File: pac_pkg.sv */
// package: constants and carrier types for the paging address code converter
package pac_pkg;

  // widths
  localparam int DEC_W  = 33;                 // decimal address width
  localparam int WORD_W = 21;                 // over-the-air word width

  // short address arithmetic
  localparam logic [32:0] SHORT_OFS   = 33'h000008000; // 32,768 offset
  localparam logic [32:0] SHORT_MAX   = 33'h0001d8000; // 1,933,312
  localparam logic [32:0] SHORT_LIM   = 33'h0001effff; // 2,031,615
  localparam logic [32:0] ILL_HI      = 33'h000201000; // 2,101,248

  // long address arithmetic
  localparam logic [32:0] L12_BASE    = 33'h0001f9001; // 2,068,481
  localparam logic [32:0] L12_REBASE  = 33'h0001f9000; // 2,068,480
  localparam logic [32:0] L23_BASE    = 33'h0001f8fff; // 2,068,479
  localparam logic [20:0] ONES_21     = 21'h1fffff;    // 2,097,151
  localparam logic [20:0] L3_OFS      = 21'h1d8000;    // 1,933,312
  localparam logic [20:0] L23_W1_OFS  = 21'h1f7fff;    // 2,064,383
  localparam logic [20:0] L23_W2_OFS  = 21'h1c8000;    // 1,867,776

  // long range ends
  localparam logic [32:0] L12_END     = 33'h040201000; // 1,075,843,072
  localparam logic [32:0] L13_END     = 33'h080201000; // 2,149,584,896
  localparam logic [32:0] L14_END     = 33'h0c0201000; // 3,223,326,720
  localparam logic [32:0] L23_END     = 33'h100200ffe; // 4,297,068,542

  // ascii type letters
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] CH_Z = 8'h5a;

  // phase type of an address
  typedef enum logic [1:0] {
    PAC_SINGLE = 2'b00,
    PAC_ANY    = 2'b01,
    PAC_ALL    = 2'b10,
    PAC_BADT   = 2'b11
  } pac_ptype_t;

  // classification of a decimal value
  typedef enum logic [2:0] {
    PAC_CL_ILLEGAL = 3'b000,
    PAC_CL_SHORT   = 3'b001,
    PAC_CL_L12     = 3'b010,
    PAC_CL_L13     = 3'b011,
    PAC_CL_L14     = 3'b100,
    PAC_CL_L23     = 3'b101,
    PAC_CL_UNDEF   = 3'b110
  } pac_class_t;

  // conversion direction
  typedef enum logic [1:0] {
    PAC_OP_TO_WORDS = 2'b00,
    PAC_OP_SHORT_BK = 2'b01,
    PAC_OP_L12_BK   = 2'b10
  } pac_op_t;

  // decoded type letter
  typedef struct packed {
    pac_ptype_t  ptype;     // phase type
    logic [1:0]  sub;       // subtract value (standard) or fixed phase
    logic        standard;  // standard embedding rule applies
    logic        fixed_ph;  // nonstandard with fixed phase
    logic        bad;       // unrecognised letter
  } pac_type_t;

  // request
  typedef struct packed {
    pac_op_t     op;
    logic [7:0]  letter;
    logic [32:0] dec;
    logic [20:0] w1;
    logic [20:0] w2;
  } pac_req_t;

  // result
  typedef struct packed {
    pac_class_t  cls;
    pac_ptype_t  ptype;
    logic [1:0]  phase;
    logic [6:0]  frame;
    logic        two_words;
    logic [20:0] w1;
    logic [20:0] w2;
    logic [32:0] dec;
    logic        err;
  } pac_rsp_t;

endpackage

/* File: pac_letter_dec.sv */
// module: combinational decoder of the address type letter
module pac_letter_dec
  import pac_pkg::*;
(
  // letter in
  input  wire logic [7:0]        letter,
  // decoded type
  output pac_pkg::pac_type_t     typ
);

  logic [7:0] ofs; // letter distance from A (standard) or from U (fixed phase)

  // classify the letter into phase type and subtract or phase
  always_comb begin
    ofs = 8'h00;
    typ = '{ptype: PAC_BADT, sub: 2'b00, standard: 1'b0,
            fixed_ph: 1'b0, bad: 1'b1};
    if (letter >= CH_A && letter <= CH_L) begin
      // standard forms, four letters per set
      ofs          = letter - CH_A;
      typ.standard = 1'b1;
      typ.bad      = 1'b0;
      typ.sub      = ofs[1:0]; // [R1]
      unique case (ofs[3:2])
        2'b00:   typ.ptype = PAC_SINGLE; // [R1]
        2'b01:   typ.ptype = PAC_ANY;
        default: typ.ptype = PAC_ALL;
      endcase
    end else if (letter >= CH_U && letter <= CH_X) begin
      // nonstandard single phase, phase fixed by letter
      ofs          = letter - CH_U;
      typ.ptype    = PAC_SINGLE;
      typ.sub      = ofs[1:0]; // [R3]
      typ.fixed_ph = 1'b1;
      typ.bad      = 1'b0;
    end else if (letter == CH_Y) begin
      // nonstandard any phase
      typ.ptype = PAC_ANY; // [R3]
      typ.bad   = 1'b0;
    end else if (letter == CH_Z) begin
      // nonstandard all phase
      typ.ptype = PAC_ALL; // [R3]
      typ.bad   = 1'b0;
    end
  end

endmodule

/* File: pac_converter_properties.sv */
// checker: timing and arithmetic properties seen at the converter ports
module pac_chk
  import pac_pkg::*;
(
  // clock and reset
  input wire logic         mclk,
  input wire logic         sys_rst,
  // request and result
  input wire logic         req_valid,
  input pac_pkg::pac_req_t req,
  input wire logic         rsp_valid,
  input pac_pkg::pac_rsp_t rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic        tw;  // to-words request taken
  logic [32:0] d;   // decimal in
  logic [32:0] m12; // code less the first long base
  logic [32:0] m23; // code less the set 2-3 base
  logic        tg;  // to-words request with a known letter
  assign tw  = req_valid && req.op == PAC_OP_TO_WORDS;
  assign d   = req.dec;
  assign m12 = d - L12_BASE;
  assign m23 = d - L23_BASE;
  assign tg  = tw && (req.letter inside {[CH_A:CH_L], [CH_U:CH_Z]});
  a_short_word_out:
    assert property (tg && d >= 33'h1 && d <= SHORT_MAX |=> rsp_valid
      && !rsp.err && rsp.w1 == $past(d[20:0]) + SHORT_OFS[20:0])
    else $error("short word wrong");
  a_long_first_word:
    assert property (tg && d > ILL_HI && d <= L14_END
      |=> rsp.w1 == $past(m12[14:0]) + 21'h1) else $error("first word wrong");
  a_l12_second_word:
    assert property (tg && d > ILL_HI && d <= L12_END
      |=> rsp.w2 == ONES_21 - $past(m12[32:15])) else $error("l12 w2 wrong");
  a_l134_second_word:
    assert property (tg && d > L12_END && d <= L14_END
      |=> rsp.w2 == $past(m12[32:15]) + L3_OFS) else $error("l134 w2 wrong");
  a_l23_first_word:
    assert property (tg && d > L14_END && d <= L23_END
      |=> rsp.w1 == $past(m23[14:0]) + L23_W1_OFS) else $error("l23 w1 wrong");
  a_l23_second_word:
    assert property (tg && d > L14_END && d <= L23_END
      |=> rsp.w2 == $past(m23[32:15]) + L23_W2_OFS) else $error("l23 w2 wrong");
  a_illegal_gives_err:
    assert property (tw && (d == 33'h0 || (d >= SHORT_LIM && d <= ILL_HI))
      |=> rsp.err && rsp.w1 == 21'h0 && rsp.w2 == 21'h0)
    else $error("illegal value not flagged");
  a_bad_letter_err:
    assert property (tw && req.letter inside {[8'h4d:8'h54]} |=> rsp.err)
    else $error("bad letter not flagged");
  a_fixed_phase_out:
    assert property (tw && req.letter inside {[CH_U:CH_X]} && d == 33'h1
      |=> rsp.phase == $past(req.letter[1:0]) - 2'h1) else $error("phase");
  a_short_back_dec:
    assert property (req_valid && req.op == PAC_OP_SHORT_BK
      && req.w1 == 21'h8001 |=> rsp.dec == 33'h1)
    else $error("short back wrong");
endmodule

/* File: testbench.sv */
// testbench: directed scenarios for the address code converter
module testbench
  import pac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic     mclk = 0;
  logic     sys_rst = 1;
  logic     req_valid = 0;
  pac_req_t req = '0;
  logic     rsp_valid;
  pac_rsp_t rsp;
  int       n_fail = 0;
  int       checks_done = 0;
  longint   lc[7] = '{64'd2101249, 64'd1075843072, 64'd1075843073,
                      64'd2149584896, 64'd2149584897, 64'd3223326721,
                      64'd4297068542};
  pac_class_t lk[7] = '{PAC_CL_L12, PAC_CL_L12, PAC_CL_L13, PAC_CL_L13,
                        PAC_CL_L14, PAC_CL_L23, PAC_CL_L23};
  logic [32:0] bad[4] = '{0, 2031615, 2101248, 33'd4297068543};
  always #50 mclk = ~mclk;
  pac_converter uut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  task chk(string nm, logic [32:0] seen, logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, result sampled just after the answering edge
  task send(pac_op_t op, logic [7:0] l, logic [32:0] d, logic [20:0] a,
            logic [20:0] b);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{op, l, d, a, b};
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    chk("rsp_valid", rsp_valid, 1);
  endtask
  task t_letters();
    logic [32:0] d;
    for (int i = 0; i < 12; i++) begin
      send(PAC_OP_TO_WORDS, 8'h41 + i[7:0], 33'd91, 0, 0);
      d = 33'd91 - i % 4;
      chk("ptype", rsp.ptype, i / 4);
      chk("phase", rsp.phase, d[3:2]);
      chk("frame", rsp.frame, d[10:4]);
    end
    for (int i = 0; i < 6; i++) begin
      send(PAC_OP_TO_WORDS, CH_U + i[7:0], 33'd1, 0, 0);
      chk("ptype", rsp.ptype, i < 4 ? 0 : i - 3);
      if (i < 4) chk("phase", rsp.phase, i);
    end
    send(PAC_OP_TO_WORDS, 8'h4d, 33'd1, 0, 0);
    chk("err", rsp.err, 1);
  endtask
  task t_short();
    foreach (bad[i]) begin
      send(PAC_OP_TO_WORDS, CH_A, bad[i], 0, 0);
      chk("err", rsp.err, 1);
      chk("w1", rsp.w1, 0);
      chk("cls", rsp.cls, i < 3 ? PAC_CL_ILLEGAL : PAC_CL_UNDEF);
    end
    for (int i = 0; i < 2; i++) begin
      send(PAC_OP_TO_WORDS, CH_A, i ? 33'd1933312 : 33'd1, 0, 0);
      chk("w1", rsp.w1, (i ? 1933312 : 1) + 32768);
      chk("cls", rsp.cls, PAC_CL_SHORT);
      chk("two", rsp.two_words, 0);
    end
  endtask
  task t_long();
    longint k, q, r;
    foreach (lc[i]) begin
      send(PAC_OP_TO_WORDS, CH_E, lc[i][32:0], 0, 0);
      k = lc[i] > 64'd3223326720 ? 2068479 : 2068481;
      q = (lc[i] - k) / 32768;
      r = (lc[i] - k) % 32768;
      chk("cls", rsp.cls, lk[i]);
      chk("two", rsp.two_words, 1);
      if (i < 2) chk("w2", rsp.w2, 2097151 - q);
      else if (i < 5) chk("w2", rsp.w2, q + 1933312);
      else chk("w2", rsp.w2, q + 1867776);
      chk("w1", rsp.w1, i < 5 ? r + 1 : r + 2064383);
    end
  endtask
  task t_back();
    send(PAC_OP_SHORT_BK, CH_A, 0, 21'h8001, 0);
    chk("dec", rsp.dec, 1);
    chk("err", rsp.err, 0);
    send(PAC_OP_L12_BK, CH_A, 0, 21'd5, 21'd2097148);
    chk("dec", rsp.dec, 3 * 32768 + 2068480 + 5);
    chk("err", rsp.err, 0);
    send(PAC_OP_SHORT_BK, CH_A, 0, 21'h8000, 0);
    chk("err", rsp.err, 1);
    send(PAC_OP_L12_BK, CH_A, 0, 21'h0, 21'd2097148);
    chk("err", rsp.err, 1);
  endtask
  // second address of a unit keeps the first one's frame and phase
  task t_pair();
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 2; k++) begin
        send(PAC_OP_TO_WORDS, CH_A + 8'(4 * j + k), 33'd1000 + k, 0, 0);
        chk("phase", rsp.phase, 2);
        chk("frame", rsp.frame, 62);
      end
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_letters();
    t_short();
    t_long();
    t_back();
    t_pair();
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule
bind pac_converter pac_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
